// ---- hw/tbd_defines.svh ----
`ifndef TBD_DEFINES_SVH
`define TBD_DEFINES_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define TBD_ADDR_W          4
`define TBD_OFS_STATUS      4'h0
`define TBD_OFS_DIAG        4'h1
`define TBD_OFS_COMMAND     4'h2
`define TBD_OFS_CONFIG      4'h3
`define TBD_OFS_SETUP       4'h4
`define TBD_OFS_MASK        4'h5
`define TBD_OFS_PROBE_ID    4'h6
`define TBD_OFS_SUCC_ID     4'h7
`define TBD_OFS_NACK_CNT    4'h8

// ------------------------------------------------------------
// status bits (also interrupt mask bits, same positions)
// ------------------------------------------------------------
`define TBD_ST_TX_AVAIL     0
`define TBD_ST_TX_ACKED     1
`define TBD_ST_RX_INHIB     2
`define TBD_ST_EXCESS_NACK_FLAG       3
`define TBD_ST_RECON        4
`define TBD_ST_SUCC_CHG     5
`define TBD_IRQ_SRC_N       5

// ------------------------------------------------------------
// diagnostic status bits
// ------------------------------------------------------------
`define TBD_DG_OWN_ID       0
`define TBD_DG_PROBE_ID     1
`define TBD_DG_EXCESS_NACK_FLAG       2
`define TBD_DG_IN_NET       3

// ------------------------------------------------------------
// config and setup bits
// ------------------------------------------------------------
`define TBD_CFG_CHAIN       0
`define TBD_SET_SHORT_NACK  0

// ------------------------------------------------------------
// commands written to the command register
// ------------------------------------------------------------
`define TBD_CMD_DIS_TX      8'h01
`define TBD_CMD_CLR_FLAGS   8'h02
`define TBD_CMD_EN_TX       8'h03
`define TBD_CMD_EN_RX       8'h04

// ------------------------------------------------------------
// limits and reset values
// ------------------------------------------------------------
`define TBD_NACK_LIMIT_LONG  8'h80
`define TBD_NACK_LIMIT_SHORT 8'h04
`define TBD_NACK_MAX         8'hff
`define TBD_RST_MASK         5'h00
`define TBD_RST_ID           8'h00
`define TBD_RST_BYTE         8'h00

`endif

// ---- hw/tbd_pkg.sv ----
package tbd_pkg;

  typedef logic [7:0] tbd_byte_t;

  typedef enum logic {
    TBD_TX_IDLE,
    TBD_TX_BUSY
  } tbd_tx_state_e;

endpackage

// ---- hw/tbd_nack_counter.sv ----
`timescale 1ns/1ps
`include "tbd_defines.svh"

module tbd_nack_counter
  import tbd_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      nrst,
  input  wire logic      clear,
  input  wire logic      nack,
  input  wire logic      short_sel,
  output tbd_byte_t      count,
  output logic           limit_hit
);

  tbd_byte_t limit;
  tbd_byte_t next_count;

  assign limit      = short_sel ? `TBD_NACK_LIMIT_SHORT : `TBD_NACK_LIMIT_LONG;
  assign next_count = (count == `TBD_NACK_MAX) ? count : tbd_byte_t'(count + 8'h01);

  // ------------------------------------------------------------
  // count of negative answers to free-buffer enquiries
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count <= `TBD_RST_BYTE;
    end else if (clear) begin
      count <= `TBD_RST_BYTE;
    end else if (nack) begin
      count <= next_count;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      limit_hit <= 1'b0;
    end else begin
      limit_hit <= !clear && nack && (next_count == limit) && (count != limit);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_limit_hit;
    !clear && nack && (count == tbd_byte_t'(limit - 8'h01)) |=> limit_hit;
  endproperty
  a_limit_hit: assert property (p_limit_hit) else $error("limit not flagged at count");

  property p_short_limit;
    short_sel && !clear && nack && (count == tbd_byte_t'(`TBD_NACK_LIMIT_SHORT - 8'h01)) |=>
      limit_hit && (count == `TBD_NACK_LIMIT_SHORT);
  endproperty
  a_short_limit: assert property (p_short_limit) else $error("short limit is not four");

endmodule

// ---- hw/tbd_diag_flags.sv ----
`timescale 1ns/1ps
`include "tbd_defines.svh"

// Summary of operation
// - transmit done sets available flag, can interrupt
// - acked flag reports last packet received ok
// - config register holds readable chaining enable
// - count nacked enquiries, interrupt at limit
// - limit 128, four with short select
// - enquiries continue after limit until abort
// - disable transmitter abandons packet, stops retries
// - clear flags drops excess nack interrupt
// - own id echo sets flag while networked
// - reading diagnostic status clears own id flag
// - probe id register, token sets seen flag
// - probe detector blind to own successor id
// - successor id register is readable
// - successor update raises successor changed interrupt
// - successor updates on mini or full reconfiguration
// - all sources except the acked flag merge onto one interrupt
module tbd_diag_flags
  import tbd_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic [`TBD_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output tbd_byte_t                   reg_rdata,
  input  wire logic                   tx_done,
  input  wire logic                   tx_ack_ok,
  input  wire logic                   fbe_nacked,
  input  wire logic                   rx_done,
  input  wire logic                   node_in_network,
  input  wire logic                   own_token_echo,
  input  wire logic                   token_seen,
  input  wire logic [7:0]             token_dest_id,
  input  wire logic                   tx_active,
  input  wire logic                   recon_mini,
  input  wire logic                   recon_full,
  input  wire logic [7:0]             successor_new_id,
  output logic                        tx_enable,
  output logic                        fbe_retry_en,
  output logic                        chain_en,
  output logic                        core_irq
);

  // ------------------------------------------------------------
  // register strobes and command decode
  // ------------------------------------------------------------
  logic wr_cmd;
  logic cmd_dis_tx;
  logic cmd_clr_flags;
  logic cmd_en_tx;
  logic cmd_en_rx;
  logic rd_diag;
  logic recon_any;
  logic probe_hit;
  logic limit_hit;

  assign wr_cmd        = reg_wr && (reg_addr == `TBD_OFS_COMMAND);
  assign cmd_dis_tx    = wr_cmd && (reg_wdata == `TBD_CMD_DIS_TX);
  assign cmd_clr_flags = wr_cmd && (reg_wdata == `TBD_CMD_CLR_FLAGS);
  assign cmd_en_tx     = wr_cmd && (reg_wdata == `TBD_CMD_EN_TX);
  assign cmd_en_rx     = wr_cmd && (reg_wdata == `TBD_CMD_EN_RX);
  assign rd_diag       = reg_rd && (reg_addr == `TBD_OFS_DIAG);
  assign recon_any     = recon_mini || recon_full;

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  logic                     short_nack_limit_sel;
  logic [`TBD_IRQ_SRC_N:0]  irq_mask;
  tbd_byte_t                probe_id_register;
  tbd_byte_t                successor_id_register;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      chain_en <= 1'b0;
    end else if (reg_wr && (reg_addr == `TBD_OFS_CONFIG)) begin
      chain_en <= reg_wdata[`TBD_CFG_CHAIN];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      short_nack_limit_sel <= 1'b0;
    end else if (reg_wr && (reg_addr == `TBD_OFS_SETUP)) begin
      short_nack_limit_sel <= reg_wdata[`TBD_SET_SHORT_NACK];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask <= {1'b0, `TBD_RST_MASK};
    end else if (reg_wr && (reg_addr == `TBD_OFS_MASK)) begin
      irq_mask <= reg_wdata[`TBD_IRQ_SRC_N:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      probe_id_register <= `TBD_RST_ID;
    end else if (reg_wr && (reg_addr == `TBD_OFS_PROBE_ID)) begin
      probe_id_register <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      successor_id_register <= `TBD_RST_ID;
    end else if (recon_any) begin
      successor_id_register <= successor_new_id;
    end
  end

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  tbd_tx_state_e tx_state;
  logic          tx_available_flag;
  logic          tx_acked_flag;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_state <= TBD_TX_IDLE;
    end else begin
      case (tx_state)
        TBD_TX_IDLE: begin
          if (cmd_en_tx) begin
            tx_state <= TBD_TX_BUSY;
          end
        end
        TBD_TX_BUSY: begin
          if (cmd_dis_tx || tx_done) begin
            tx_state <= TBD_TX_IDLE;
          end
        end
        default: begin
          tx_state <= TBD_TX_IDLE;
        end
      endcase
    end
  end

  // retries go on while busy, whatever the nack count says
  assign tx_enable    = (tx_state == TBD_TX_BUSY);
  assign fbe_retry_en = (tx_state == TBD_TX_BUSY);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_available_flag <= 1'b1;
    end else if (tx_done || cmd_dis_tx) begin
      tx_available_flag <= 1'b1;
    end else if (cmd_en_tx) begin
      tx_available_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_acked_flag <= 1'b0;
    end else if (tx_done) begin
      tx_acked_flag <= tx_ack_ok;
    end else if (cmd_en_tx || cmd_dis_tx) begin
      tx_acked_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // excessive nack
  // ------------------------------------------------------------
  tbd_byte_t nack_count;
  logic      excess_nack_flag;

  tbd_nack_counter u_nack_counter (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .clear     (cmd_en_tx || cmd_dis_tx || tx_done),
    .nack      (fbe_nacked && (tx_state == TBD_TX_BUSY)),
    .short_sel (short_nack_limit_sel),
    .count     (nack_count),
    .limit_hit (limit_hit)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      excess_nack_flag <= 1'b0;
    end else if (limit_hit) begin
      excess_nack_flag <= 1'b1;
    end else if (cmd_clr_flags) begin
      excess_nack_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // receive, reconfiguration and successor events
  // ------------------------------------------------------------
  logic rx_inhibited_flag;
  logic recon_flag;
  logic successor_changed_irq;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_inhibited_flag <= 1'b0;
    end else if (rx_done) begin
      rx_inhibited_flag <= 1'b1;
    end else if (cmd_en_rx) begin
      rx_inhibited_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      recon_flag <= 1'b0;
    end else if (recon_any) begin
      recon_flag <= 1'b1;
    end else if (cmd_clr_flags) begin
      recon_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      successor_changed_irq <= 1'b0;
    end else if (recon_any) begin
      successor_changed_irq <= 1'b1;
    end else if (cmd_clr_flags) begin
      successor_changed_irq <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // duplicate and probe id detection
  // ------------------------------------------------------------
  logic own_id_seen_flag;
  logic probe_id_seen_flag;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      own_id_seen_flag <= 1'b0;
    end else if (node_in_network && own_token_echo) begin
      own_id_seen_flag <= 1'b1;
    end else if (rd_diag) begin
      own_id_seen_flag <= 1'b0;
    end
  end

  // receiver is deaf while passing the token to the successor
  assign probe_hit = token_seen && !tx_active && (token_dest_id == probe_id_register) &&
                     (token_dest_id != successor_id_register);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      probe_id_seen_flag <= 1'b0;
    end else if (probe_hit) begin
      probe_id_seen_flag <= 1'b1;
    end else if (cmd_clr_flags) begin
      probe_id_seen_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupt merge and read port
  // ------------------------------------------------------------
  logic [`TBD_IRQ_SRC_N:0] status;
  tbd_byte_t               diag;

  assign status = {successor_changed_irq, recon_flag, excess_nack_flag,
                   rx_inhibited_flag, tx_acked_flag, tx_available_flag};
  assign diag   = {4'h0, node_in_network, excess_nack_flag, probe_id_seen_flag, own_id_seen_flag};

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      core_irq <= 1'b0;
    end else begin
      // acked flag is status only, not an interrupt source
      core_irq <= |(status & irq_mask & ~(6'h01 << `TBD_ST_TX_ACKED));
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `TBD_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `TBD_OFS_STATUS:   reg_rdata <= {2'h0, status};
        `TBD_OFS_DIAG:     reg_rdata <= diag;
        `TBD_OFS_CONFIG:   reg_rdata <= {7'h00, chain_en};
        `TBD_OFS_SETUP:    reg_rdata <= {7'h00, short_nack_limit_sel};
        `TBD_OFS_MASK:     reg_rdata <= {2'h0, irq_mask};
        `TBD_OFS_PROBE_ID: reg_rdata <= probe_id_register;
        `TBD_OFS_SUCC_ID:  reg_rdata <= successor_id_register;
        `TBD_OFS_NACK_CNT: reg_rdata <= nack_count;
        default:           reg_rdata <= `TBD_RST_BYTE;
      endcase
    end else begin
      reg_rdata <= `TBD_RST_BYTE;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_tx_avail;
    tx_done |=> tx_available_flag && !tx_enable;
  endproperty
  a_tx_avail: assert property (p_tx_avail) else $error("tx done did not free transmitter");

  property p_tx_acked;
    tx_done |=> (tx_acked_flag == $past(tx_ack_ok));
  endproperty
  a_tx_acked: assert property (p_tx_acked) else $error("acked flag wrong after tx");

  property p_chain;
    reg_wr && (reg_addr == `TBD_OFS_CONFIG) |=> (chain_en == $past(reg_wdata[`TBD_CFG_CHAIN]));
  endproperty
  a_chain: assert property (p_chain) else $error("chaining bit not stored");

  // interrupt follows the flag by one edge, under the mask of that cycle
  property p_excess_nack_flag_set;
    limit_hit |=> excess_nack_flag ##1 (core_irq || !$past(irq_mask[`TBD_ST_EXCESS_NACK_FLAG]));
  endproperty
  a_excess_nack_flag_set: assert property (p_excess_nack_flag_set) else $error("excess nack not raised");

  property p_retry_go_on;
    excess_nack_flag && tx_enable && !cmd_dis_tx && !tx_done |=> fbe_retry_en;
  endproperty
  a_retry_go_on: assert property (p_retry_go_on) else $error("retries stopped at limit");

  property p_disable;
    cmd_dis_tx |=> !fbe_retry_en && !tx_enable && (nack_count == `TBD_RST_BYTE);
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not abandon tx");

  property p_clear_flags;
    cmd_clr_flags && !limit_hit |=> !excess_nack_flag;
  endproperty
  a_clear_flags: assert property (p_clear_flags) else $error("clear flags kept excess nack");

  property p_own_id;
    node_in_network && own_token_echo |=> own_id_seen_flag;
  endproperty
  a_own_id: assert property (p_own_id) else $error("own id echo missed");

  property p_diag_read;
    rd_diag && !(node_in_network && own_token_echo) |=> !own_id_seen_flag;
  endproperty
  a_diag_read: assert property (p_diag_read) else $error("diag read did not clear");

  property p_probe;
    token_seen && !tx_active && (token_dest_id == probe_id_register) &&
      (token_dest_id != successor_id_register) |=> probe_id_seen_flag;
  endproperty
  a_probe: assert property (p_probe) else $error("probe id token missed");

  property p_probe_blind;
    !probe_id_seen_flag && token_seen && tx_active && !recon_any |=> !probe_id_seen_flag;
  endproperty
  a_probe_blind: assert property (p_probe_blind) else $error("probe seen while passing token");

  property p_successor;
    recon_any |=> (successor_id_register == $past(successor_new_id)) && successor_changed_irq;
  endproperty
  a_successor: assert property (p_successor) else $error("successor update wrong");

  property p_irq_merge;
    |(status & irq_mask & 6'h3d) |=> core_irq;
  endproperty
  a_irq_merge: assert property (p_irq_merge) else $error("masked source did not interrupt");

  property p_irq_quiet;
    !(|(status & irq_mask & 6'h3d)) |=> !core_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without source");

  c_excess_nack_flag:    cover property (limit_hit ##[1:20] cmd_clr_flags);
  c_abort:     cover property (excess_nack_flag && cmd_dis_tx);
  c_probe:     cover property (probe_hit);
  c_successor: cover property (recon_full ##[1:20] recon_mini);

endmodule

// ---- tb/tbd_net_model.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// far side: other nodes and the transmit/receive path
// ------------------------------------------------------------
module tbd_net_model (
  input  wire logic       sys_clk,
  output logic            tx_done,
  output logic            tx_ack_ok,
  output logic            fbe_nacked,
  output logic            rx_done,
  output logic            node_in_network,
  output logic            own_token_echo,
  output logic            token_seen,
  output logic [7:0]      token_dest_id,
  output logic            tx_active,
  output logic            recon_mini,
  output logic            recon_full,
  output logic [7:0]      successor_new_id
);
  initial begin
    {tx_done, tx_ack_ok, fbe_nacked, rx_done, node_in_network, own_token_echo} = 6'h00;
    {token_seen, tx_active, recon_mini, recon_full} = 4'h0;
    token_dest_id    = 8'h00;
    successor_new_id = 8'h00;
  end

  task automatic levels(input logic in_net, input logic act);
    @(posedge sys_clk);
    node_in_network <= in_net;
    tx_active       <= act;
  endtask

  // destination answer rides on the done pulse
  task automatic tx(input logic ok);
    @(posedge sys_clk);
    tx_done   <= 1'b1;
    tx_ack_ok <= ok;
    @(posedge sys_clk);
    tx_done   <= 1'b0;
    tx_ack_ok <= ~ok;
  endtask

  // receiver busy, enquiry refused
  task automatic nack();
    @(posedge sys_clk);
    fbe_nacked <= 1'b1;
    @(posedge sys_clk);
    fbe_nacked <= 1'b0;
  endtask

  task automatic rx();
    @(posedge sys_clk);
    rx_done <= 1'b1;
    @(posedge sys_clk);
    rx_done <= 1'b0;
  endtask

  task automatic echo();
    @(posedge sys_clk);
    own_token_echo <= 1'b1;
    @(posedge sys_clk);
    own_token_echo <= 1'b0;
  endtask

  // id is scrambled once the token is gone
  task automatic token(input logic [7:0] id);
    @(posedge sys_clk);
    token_seen    <= 1'b1;
    token_dest_id <= id;
    @(posedge sys_clk);
    token_seen    <= 1'b0;
    token_dest_id <= ~id;
  endtask

  // node dropped (mini) or joined (full)
  task automatic recon(input logic full, input logic [7:0] id);
    @(posedge sys_clk);
    recon_mini       <= ~full;
    recon_full       <= full;
    successor_new_id <= id;
    @(posedge sys_clk);
    recon_mini       <= 1'b0;
    recon_full       <= 1'b0;
    successor_new_id <= ~id;
  endtask
endmodule

// ---- tb/tb_token_bus_diag_flags.sv ----
`timescale 1ns/1ps
`include "tbd_defines.svh"

module tb_token_bus_diag_flags import tbd_pkg::*;;
  logic                   sys_clk;
  logic                   nrst;
  logic [`TBD_ADDR_W-1:0] reg_addr;
  logic [7:0]             reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  tbd_byte_t              reg_rdata;
  logic                   tx_done, tx_ack_ok, fbe_nacked, rx_done, node_in_network, own_token_echo;
  logic                   token_seen, tx_active, recon_mini, recon_full;
  logic [7:0]             token_dest_id, successor_new_id;
  logic                   tx_enable, fbe_retry_en, chain_en, core_irq;
  int                     miscompares;
  int                     tests_run;

  tbd_diag_flags dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_done(tx_done), .tx_ack_ok(tx_ack_ok),
    .fbe_nacked(fbe_nacked), .rx_done(rx_done), .node_in_network(node_in_network),
    .own_token_echo(own_token_echo), .token_seen(token_seen), .token_dest_id(token_dest_id),
    .tx_active(tx_active), .recon_mini(recon_mini), .recon_full(recon_full),
    .successor_new_id(successor_new_id), .tx_enable(tx_enable), .fbe_retry_en(fbe_retry_en),
    .chain_en(chain_en), .core_irq(core_irq));

  tbd_net_model net (.sys_clk(sys_clk), .tx_done(tx_done), .tx_ack_ok(tx_ack_ok), .fbe_nacked(fbe_nacked),
    .rx_done(rx_done), .node_in_network(node_in_network), .own_token_echo(own_token_echo),
    .token_seen(token_seen), .token_dest_id(token_dest_id), .tx_active(tx_active),
    .recon_mini(recon_mini), .recon_full(recon_full), .successor_new_id(successor_new_id));

  // ------------------------------------------------------------
  // clock, bus tasks, compare
  // ------------------------------------------------------------
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(name, exp, reg_rdata);
  endtask

  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("core_irq", 8'h00, {7'h00, core_irq});
    chk("tx_enable", 8'h00, {7'h00, tx_enable});
    rd(`TBD_OFS_STATUS, 8'h01, "status");
    rd(`TBD_OFS_CONFIG, 8'h00, "config");
    rd(`TBD_OFS_NACK_CNT, 8'h00, "nack_cnt");
    wr(`TBD_OFS_SUCC_ID, 8'h55);
    rd(`TBD_OFS_SUCC_ID, 8'h00, "succ_id read only");
    rd(4'hf, 8'h00, "unmapped");
  endtask

  task automatic t_tx();
    wr(`TBD_OFS_MASK, 8'h01);
    settle();
    chk("irq tx avail", 8'h01, {7'h00, core_irq});
    wr(`TBD_OFS_COMMAND, `TBD_CMD_EN_TX);
    settle();
    chk("tx_enable", 8'h01, {7'h00, tx_enable});
    net.tx(1'b1);
    rd(`TBD_OFS_STATUS, 8'h03, "status acked");
    net.tx(1'b0);
    rd(`TBD_OFS_STATUS, 8'h01, "status not acked");
    wr(`TBD_OFS_MASK, 8'h00);
    settle();
    chk("irq masked", 8'h00, {7'h00, core_irq});
  endtask

  task automatic t_chain();
    wr(`TBD_OFS_CONFIG, 8'h01);
    rd(`TBD_OFS_CONFIG, 8'h01, "config");
    chk("chain_en", 8'h01, {7'h00, chain_en});
    wr(`TBD_OFS_CONFIG, 8'h00);
    settle();
    chk("chain_en off", 8'h00, {7'h00, chain_en});
  endtask

  task automatic t_excess_nack_flag(input logic short_sel, input int limit);
    wr(`TBD_OFS_SETUP, {7'h00, short_sel});
    wr(`TBD_OFS_MASK, 8'h08);
    wr(`TBD_OFS_COMMAND, `TBD_CMD_EN_TX);
    repeat (limit - 1) net.nack();
    settle();
    chk("irq below limit", 8'h00, {7'h00, core_irq});
    net.nack();
    settle();
    chk("irq at limit", 8'h01, {7'h00, core_irq});
    rd(`TBD_OFS_DIAG, 8'h04, "diag excess_nack_flag");
    rd(`TBD_OFS_NACK_CNT, limit[7:0], "nack_cnt");
    net.nack();
    net.nack();
    chk("retry after limit", 8'h01, {7'h00, fbe_retry_en});
    wr(`TBD_OFS_COMMAND, `TBD_CMD_DIS_TX);
    settle();
    chk("tx_enable abort", 8'h00, {7'h00, tx_enable});
    chk("retry abort", 8'h00, {7'h00, fbe_retry_en});
    chk("irq held", 8'h01, {7'h00, core_irq});
    net.nack();
    rd(`TBD_OFS_NACK_CNT, 8'h00, "nack idle");
    wr(`TBD_OFS_COMMAND, `TBD_CMD_CLR_FLAGS);
    settle();
    chk("irq cleared", 8'h00, {7'h00, core_irq});
    rd(`TBD_OFS_DIAG, 8'h00, "diag cleared");
  endtask

  task automatic t_own_id();
    net.echo();
    rd(`TBD_OFS_DIAG, 8'h00, "echo off net");
    net.levels(1'b1, 1'b0);
    net.echo();
    rd(`TBD_OFS_DIAG, 8'h09, "echo on net");
    rd(`TBD_OFS_DIAG, 8'h08, "cleared by read");
  endtask

  task automatic t_successor();
    wr(`TBD_OFS_MASK, 8'h20);
    net.recon(1'b0, 8'h42);
    settle();
    chk("irq mini", 8'h01, {7'h00, core_irq});
    rd(`TBD_OFS_SUCC_ID, 8'h42, "succ mini");
    wr(`TBD_OFS_COMMAND, `TBD_CMD_CLR_FLAGS);
    settle();
    chk("irq clr", 8'h00, {7'h00, core_irq});
    net.recon(1'b1, 8'h43);
    settle();
    chk("irq full", 8'h01, {7'h00, core_irq});
    rd(`TBD_OFS_SUCC_ID, 8'h43, "succ full");
    wr(`TBD_OFS_COMMAND, `TBD_CMD_CLR_FLAGS);
  endtask

  task automatic t_probe();
    wr(`TBD_OFS_PROBE_ID, 8'h25);
    rd(`TBD_OFS_PROBE_ID, 8'h25, "probe id");
    net.levels(1'b1, 1'b1);
    net.token(8'h25);
    net.levels(1'b1, 1'b0);
    rd(`TBD_OFS_DIAG, 8'h08, "probe while tx");
    wr(`TBD_OFS_PROBE_ID, 8'h43);
    net.token(8'h43);
    rd(`TBD_OFS_DIAG, 8'h08, "probe successor");
    wr(`TBD_OFS_PROBE_ID, 8'h25);
    net.token(8'h25);
    rd(`TBD_OFS_DIAG, 8'h0a, "probe seen");
    wr(`TBD_OFS_COMMAND, `TBD_CMD_CLR_FLAGS);
    rd(`TBD_OFS_DIAG, 8'h08, "probe cleared");
  endtask

  task automatic t_merge();
    wr(`TBD_OFS_MASK, 8'h04);
    net.rx();
    settle();
    chk("irq rx", 8'h01, {7'h00, core_irq});
    wr(`TBD_OFS_COMMAND, `TBD_CMD_EN_RX);
    settle();
    chk("irq rx cleared", 8'h00, {7'h00, core_irq});
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    miscompares = 0;
    tests_run   = 0;
    nrst        = 1'b0;
    reg_addr    = 4'h0;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_tx();
    t_chain();
    t_excess_nack_flag(1'b1, 4);
    t_excess_nack_flag(1'b0, 128);
    t_own_id();
    t_successor();
    t_probe();
    t_merge();
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    wrap_up();
  end
endmodule
